// ==== hdl/ref_switch_holdover_ctrl.sv ====
// reference switching, holdover, frequency step and phase control for four PLLs
//
// Behaviour
// - a PLL whose tracked input is lost moves to another input hitlessly
// - an input is lost after a programmed count of consecutive missing pulses
// - that missing-pulse count is set per input between 2 and 16
// - each PLL has its own priority order, and switching follows it
// - revertive mode returns to the better input once valid again
// - non-revertive mode stays on the replacement input
// - holdover freezes frequency at an average set by wait and window
// - holdover wait time ranges from 0.002 s to 35 s
// - averaging window ranges from 0.004 s to 70 s
// - optional pin latching at chip reset release, off by default
// - each step moves frequency by its own programmed size, 0.001 ppt units
// - stepping works in free run and in sync mode
// - a step happens only on a register write or a pin pulse
// - step size lives in registers written by the host
// - outputs of one PLL align unless a relative delay is set
// - per-output delay code in 35 ps steps within half a period
// - per-input phase offset moves locked outputs within half a period
// - zero-delay feedback restricts first or last output to feedback
// - speed-up uses fast-lock constants until frequency and phase lock
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module ref_switch_holdover_ctrl #(
  parameter int MS_CYCLES = ref_switch_pkg::MS_CYCLES
) (
  input  wire logic                                         clock,
  input  wire logic                                         rstn,
  input  wire logic [7:0]                                   avs_address,
  input  wire logic                                         avs_read,
  input  wire logic                                         avs_write,
  input  wire logic [31:0]                                  avs_writedata,
  input  wire logic [3:0]                                   avs_byteenable,
  output logic      [31:0]                                  avs_readdata,
  output logic                                              avs_waitrequest,
  input  wire logic [ref_switch_pkg::NUM_IN-1:0]            refClkIn,
  input  wire logic                                         chipResetNPin,
  input  wire logic [ref_switch_pkg::GPIO_W-1:0]            gpioIn,
  input  wire logic                                         stepIncPin,
  input  wire logic                                         stepDecPin,
  input  wire logic [ref_switch_pkg::NUM_PLL-1:0][31:0]     pllFreqWord,
  input  wire logic [ref_switch_pkg::NUM_PLL-1:0]           pllFreqLocked,
  input  wire logic [ref_switch_pkg::NUM_PLL-1:0]           pllPhaseLocked,
  output logic      [ref_switch_pkg::NUM_PLL-1:0][31:0]     pllFreqCtl,
  output logic      [ref_switch_pkg::NUM_PLL-1:0]           pllHoldover,
  output logic      [ref_switch_pkg::NUM_PLL-1:0][2:0]      pllSelInput,
  output logic      [ref_switch_pkg::NUM_PLL-1:0]           pllSwitch,
  output logic      [ref_switch_pkg::NUM_PLL-1:0][15:0]     pllPhaseOffset,
  output logic      [ref_switch_pkg::NUM_PLL-1:0]           pllFastLock,
  output logic      [ref_switch_pkg::NUM_OUT-1:0][15:0]     outDelayCode,
  output ref_switch_pkg::out_src_t [ref_switch_pkg::NUM_OUT-1:0] outSource,
  output logic      [ref_switch_pkg::GPIO_W-1:0]            gpioLatched,
  output logic                                              gpioFreed
);
  // ==========================================
  // helpers
  function automatic logic [15:0] clampCode(input logic [15:0] code, input logic [14:0] lim);
    logic signed [16:0] c;
    logic signed [16:0] l;
    c = signed'({code[15], code});
    l = signed'({2'b00, lim});
    if (c > l) return l[15:0];
    else if (c < -l) return 16'(-l);
    else return code;
  endfunction

  function automatic logic isCfg(input logic [5:0] ix);
    return (ix == ref_switch_pkg::IX_CTRL)
        || (ix >= ref_switch_pkg::IX_LOSS  && ix < ref_switch_pkg::IX_LOSS + 6'h05)
        || (ix >= ref_switch_pkg::IX_PHASE && ix < ref_switch_pkg::IX_PHASE + 6'h05)
        || (ix >= ref_switch_pkg::IX_PLL   && ix < ref_switch_pkg::IX_OUT + 6'h0C);
  endfunction

  // ==========================================
  // register bus
  logic [31:0] cfgMem [64];
  logic        waitReq_r;
  logic [31:0] rdData_r;
  logic [31:0] statWord;
  logic [31:0] selWord;
  wire  [5:0]  regIx   = avs_address[7:2];
  wire         wrTake  = avs_write & ~waitReq_r;
  wire         stepWr  = wrTake & (regIx == ref_switch_pkg::IX_STEP);
  wire  [31:0] beMask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire  [31:0] stepCmd = avs_writedata & beMask;
  wire  [31:0] rdMux   = isCfg(regIx) ? cfgMem[regIx] :
                         (regIx == ref_switch_pkg::IX_STAT) ? statWord :
                         (regIx == ref_switch_pkg::IX_SEL)  ? selWord  : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h0000_0000;
    end else begin
      waitReq_r <= ~((avs_read | avs_write) & waitReq_r);
      rdData_r  <= (avs_read & waitReq_r) ? rdMux : rdData_r;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 64; i++) begin
      if (!rstn)
        cfgMem[i] <= (i >= 32 && i < 48 && i[1:0] == 2'b00) ? ref_switch_pkg::PRIO_RST
                                                             : 32'h0000_0000;
      else if (wrTake && regIx == 6'(i) && isCfg(6'(i)))
        cfgMem[i] <= (cfgMem[i] & ~beMask) | (avs_writedata & beMask);
    end
  end

  assign avs_readdata    = rdData_r;
  assign avs_waitrequest = waitReq_r;
  wire [31:0] ctrlWord = cfgMem[ref_switch_pkg::IX_CTRL];

  // ==========================================
  // pin synchronisers and edges
  logic [1:0] incSync_r, decSync_r, rstSync_r;
  logic       incPrev_r, decPrev_r, rstPrev_r;
  logic [ref_switch_pkg::GPIO_W-1:0] gpioS1_r, gpioS2_r, gpioLat_r;
  logic       freed_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      incSync_r <= 2'h0;
      decSync_r <= 2'h0;
      rstSync_r <= 2'h3;
      incPrev_r <= 1'b0;
      decPrev_r <= 1'b0;
      rstPrev_r <= 1'b1;
      gpioS1_r  <= '0;
      gpioS2_r  <= '0;
    end else begin
      incSync_r <= {incSync_r[0], stepIncPin};
      decSync_r <= {decSync_r[0], stepDecPin};
      rstSync_r <= {rstSync_r[0], chipResetNPin};
      incPrev_r <= incSync_r[1];
      decPrev_r <= decSync_r[1];
      rstPrev_r <= rstSync_r[1];
      gpioS1_r  <= gpioIn;
      gpioS2_r  <= gpioS1_r;
    end
  end
  wire pinInc  = incSync_r[1] & ~incPrev_r;
  wire pinDec  = decSync_r[1] & ~decPrev_r;
  wire chipRel = rstSync_r[1] & ~rstPrev_r;

  // catch straps at chip reset release; pins held by the host meanwhile
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gpioLat_r <= '0;
      freed_r   <= 1'b0;
    end else if (chipRel && ctrlWord[ref_switch_pkg::CTRL_LATCH]) begin
      gpioLat_r <= gpioS2_r;
      freed_r   <= 1'b1;
    end
  end
  assign gpioLatched = gpioLat_r;
  assign gpioFreed   = freed_r;

  // ==========================================
  // missing-pulse monitors
  logic [ref_switch_pkg::NUM_IN-1:0] inLost_r;
  for (genvar gi = 0; gi < ref_switch_pkg::NUM_IN; gi++) begin : g_in
    logic [1:0]  refSync_r;
    logic        refPrev_r;
    logic [15:0] perCnt_r;
    logic [4:0]  missCnt_r;
    ref_switch_pkg::loss_cfg_t lc;
    assign lc = ref_switch_pkg::loss_cfg_t'(cfgMem[ref_switch_pkg::IX_LOSS + 6'(gi)]);
    wire [4:0] thr  = (lc.thresh < ref_switch_pkg::LOSS_MIN) ? ref_switch_pkg::LOSS_MIN :
                      (lc.thresh > ref_switch_pkg::LOSS_MAX) ? ref_switch_pkg::LOSS_MAX :
                      lc.thresh;
    wire       edgeSeen = refSync_r[1] & ~refPrev_r;
    wire       perEnd   = (perCnt_r >= lc.period - 16'h0001);
    always_ff @(posedge clock) begin
      if (!rstn || lc.period == 16'h0000) begin
        refSync_r   <= 2'h0;
        refPrev_r   <= 1'b0;
        perCnt_r    <= 16'h0000;
        missCnt_r   <= 5'h00;
        inLost_r[gi] <= 1'b0;
      end else begin
        refSync_r <= {refSync_r[0], refClkIn[gi]};
        refPrev_r <= refSync_r[1];
        if (edgeSeen) begin
          perCnt_r     <= 16'h0000;
          missCnt_r    <= 5'h00;
          inLost_r[gi] <= 1'b0;
        end else if (perEnd) begin
          perCnt_r <= 16'h0000;
          if (missCnt_r < thr) missCnt_r <= missCnt_r + 5'h01;
          if (missCnt_r + 5'h01 >= thr) inLost_r[gi] <= 1'b1;
        end else begin
          perCnt_r <= perCnt_r + 16'h0001;
        end
      end
    end
  end
  wire [ref_switch_pkg::NUM_IN-1:0] inValid = ~inLost_r;

  // ==========================================
  // millisecond tick for history sampling
  logic [31:0] msCnt_r;
  wire         msTick = (msCnt_r == 32'(MS_CYCLES - 1));
  always_ff @(posedge clock) begin
    if (!rstn || msTick) msCnt_r <= 32'h0000_0000;
    else msCnt_r <= msCnt_r + 32'h0000_0001;
  end

  // ==========================================
  // per-PLL selection, holdover, stepping, fast lock
  for (genvar gp = 0; gp < ref_switch_pkg::NUM_PLL; gp++) begin : g_pll
    localparam logic [5:0] BASE = ref_switch_pkg::IX_PLL + 6'(gp * 4);
    ref_switch_pkg::pll_cfg_t pc;
    ref_switch_pkg::sel_state_t state_r;
    logic [2:0]  sel_r, best, bestRank, curRank;
    logic        anyValid, sw_r, fastArm_r, fastLock_r;
    logic [31:0] offset_r, ctl_r, lastWord_r, pend_r, mature_r;
    logic [15:0] phase_r, pendAge_r;
    logic        pendValid_r, matureValid_r, divBusy_r;
    logic [48:0] sum_r, quo_r;
    logic [16:0] cnt_r, divisor_r;
    logic [17:0] rem_r;
    logic [5:0]  divCnt_r;
    assign pc = ref_switch_pkg::pll_cfg_t'(cfgMem[BASE + {4'h0, ref_switch_pkg::PW_CFG}]);
    wire [15:0] waitRaw = cfgMem[BASE + {4'h0, ref_switch_pkg::PW_WAIT}][15:0];
    wire [16:0] winRaw  = cfgMem[BASE + {4'h0, ref_switch_pkg::PW_WIN}][16:0];
    wire [31:0] stepSz  = cfgMem[BASE + {4'h0, ref_switch_pkg::PW_SIZE}];
    wire [15:0] waitMs = (waitRaw < ref_switch_pkg::WAIT_MIN) ? ref_switch_pkg::WAIT_MIN :
                         (waitRaw > ref_switch_pkg::WAIT_MAX) ? ref_switch_pkg::WAIT_MAX :
                         waitRaw;
    wire [16:0] winMs  = (winRaw < ref_switch_pkg::WIN_MIN) ? ref_switch_pkg::WIN_MIN :
                         (winRaw > ref_switch_pkg::WIN_MAX) ? ref_switch_pkg::WIN_MAX :
                         winRaw;

    // highest-ranked valid entry of this PLL's own order
    always_comb begin
      best     = sel_r;
      bestRank = 3'h7;
      curRank  = 3'h7;
      anyValid = 1'b0;
      for (int r = ref_switch_pkg::NUM_IN - 1; r >= 0; r--) begin
        if (pc.prio[r*3 +: 3] < 3'(ref_switch_pkg::NUM_IN) && inValid[pc.prio[r*3 +: 3]]) begin
          best     = pc.prio[r*3 +: 3];
          bestRank = 3'(r);
          anyValid = 1'b1;
        end
        if (pc.prio[r*3 +: 3] == sel_r) curRank = 3'(r);
      end
    end
    wire curLost = ~inValid[sel_r];
    wire doSw    = (state_r == ref_switch_pkg::ST_HOLD) ? anyValid :
                   anyValid & (curLost | (pc.revertive & (bestRank < curRank)));

    always_ff @(posedge clock) begin
      if (!rstn) begin
        state_r <= ref_switch_pkg::ST_TRACK;
        sel_r   <= 3'h0;
        sw_r    <= 1'b0;
      end else begin
        sw_r <= doSw;
        if (doSw) begin
          sel_r   <= best;
          state_r <= ref_switch_pkg::ST_TRACK;
        end else if (!anyValid) begin
          state_r <= ref_switch_pkg::ST_HOLD;
        end
      end
    end
    wire inHold = (state_r == ref_switch_pkg::ST_HOLD);

    // history: window averages aged by the wait time before use
    wire [17:0] remSh = {rem_r[16:0], quo_r[48]};
    wire        remGe = remSh >= {1'b0, divisor_r};
    wire        winEnd = msTick & ~inHold & ~divBusy_r & (cnt_r + 17'h00001 >= winMs);
    always_ff @(posedge clock) begin
      if (!rstn) begin
        sum_r <= '0; cnt_r <= '0; divBusy_r <= 1'b0; divCnt_r <= '0;
        quo_r <= '0; rem_r <= '0; divisor_r <= '0;
      end else begin
        if (winEnd) begin
          quo_r     <= sum_r + {17'h00000, pllFreqWord[gp]};
          divisor_r <= winMs;
          rem_r     <= '0;
          divCnt_r  <= '0;
          divBusy_r <= 1'b1;
          sum_r     <= '0;
          cnt_r     <= '0;
        end else if (msTick && !inHold) begin
          sum_r <= sum_r + {17'h00000, pllFreqWord[gp]};
          cnt_r <= cnt_r + 17'h00001;
        end
        if (divBusy_r) begin
          rem_r    <= remGe ? (remSh - {1'b0, divisor_r}) : remSh;
          quo_r    <= {quo_r[47:0], remGe};
          divCnt_r <= divCnt_r + 6'h01;
          if (divCnt_r == 6'd48) divBusy_r <= 1'b0;
        end
      end
    end
    wire divDone = divBusy_r & (divCnt_r == 6'd48);

    always_ff @(posedge clock) begin
      if (!rstn) begin
        pend_r <= '0; pendValid_r <= 1'b0; pendAge_r <= '0;
        mature_r <= '0; matureValid_r <= 1'b0; lastWord_r <= '0;
      end else begin
        if (!inHold) lastWord_r <= pllFreqWord[gp];
        if (divDone && !pendValid_r) begin
          pend_r      <= {quo_r[30:0], remGe};
          pendValid_r <= 1'b1;
          pendAge_r   <= '0;
        end else if (msTick && pendValid_r) begin
          if (pendAge_r >= waitMs) begin
            mature_r      <= pend_r;
            matureValid_r <= 1'b1;
            pendValid_r   <= 1'b0;
          end else begin
            pendAge_r <= pendAge_r + 16'h0001;
          end
        end
      end
    end

    // frequency steps, free run or locked alike
    wire stepUp = (stepWr & stepCmd[gp])     | (pc.pinStep & pinInc);
    wire stepDn = (stepWr & stepCmd[gp + 4]) | (pc.pinStep & pinDec);
    wire [31:0] baseWord = !inHold ? pllFreqWord[gp] :
                           matureValid_r ? mature_r : lastWord_r;
    always_ff @(posedge clock) begin
      if (!rstn) begin
        offset_r  <= '0;
        ctl_r     <= '0;
        phase_r   <= '0;
        fastArm_r <= 1'b1;
        fastLock_r <= 1'b0;
      end else begin
        fastLock_r <= fastArm_r & pc.speedUp;
        if (stepUp && !stepDn) offset_r <= offset_r + stepSz;
        else if (stepDn && !stepUp) offset_r <= offset_r - stepSz;
        ctl_r   <= baseWord + offset_r;
        phase_r <= clampCode(cfgMem[ref_switch_pkg::IX_PHASE + {3'h0, sel_r}][15:0],
                             cfgMem[ref_switch_pkg::IX_PHASE + {3'h0, sel_r}][30:16]);
        if (!pc.speedUp) fastArm_r <= 1'b1;
        else if (pllFreqLocked[gp] && pllPhaseLocked[gp]) fastArm_r <= 1'b0;
      end
    end
    assign pllFreqCtl[gp]     = ctl_r;
    assign pllHoldover[gp]    = inHold; // state_r is a flop
    assign pllSelInput[gp]    = sel_r;
    assign pllSwitch[gp]      = sw_r;
    assign pllPhaseOffset[gp] = phase_r;
    assign pllFastLock[gp]    = fastLock_r;
    assign selWord[gp*8 +: 8] = {4'h0, inHold, sel_r};
  end

  // ==========================================
  // per-output delay and source
  for (genvar go = 0; go < ref_switch_pkg::NUM_OUT; go++) begin : g_out
    ref_switch_pkg::out_cfg_t oc;
    ref_switch_pkg::out_src_t src;
    logic [15:0] dly_r;
    ref_switch_pkg::out_src_t src_r;
    assign oc = ref_switch_pkg::out_cfg_t'(cfgMem[ref_switch_pkg::IX_OUT + 6'(go)]);
    always_comb begin
      src = oc.src;
      if (go == 0 && ctrlWord[ref_switch_pkg::CTRL_FBK0])
        src = '{feedback: 1'b1, pll: {1'b0, oc.src.pll[0]}};
      if (go == ref_switch_pkg::NUM_OUT - 1 && ctrlWord[ref_switch_pkg::CTRL_FBK1])
        src = '{feedback: 1'b1, pll: {1'b1, oc.src.pll[0]}};
    end
    always_ff @(posedge clock) begin
      if (!rstn) begin
        dly_r <= '0;
        src_r <= '0;
      end else begin
        dly_r <= clampCode(oc.code, {3'h0, oc.limit});
        src_r <= src;
      end
    end
    assign outDelayCode[go] = dly_r;
    assign outSource[go]    = src_r;
  end

  assign statWord = {12'h000, gpioLat_r, 3'h0, freed_r, 4'h0, 3'h0, inLost_r};

endmodule // ref_switch_holdover_ctrl

// ==== hdl/ref_switch_pkg.sv ====
// shared constants and carriers for the reference switch and holdover block
package ref_switch_pkg;
  // ==========================================
  // sizes and timing
  localparam int NUM_IN       = 5;
  localparam int NUM_PLL      = 4;
  localparam int NUM_OUT      = 12;
  localparam int GPIO_W       = 4;
  localparam int CLK_HZ       = 50_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int MS_CYCLES    = CLK_HZ / MS_PER_S;
  localparam logic [4:0]  LOSS_MIN = 5'h02;
  localparam logic [4:0]  LOSS_MAX = 5'h10;
  localparam logic [15:0] WAIT_MIN = 16'h0002;
  localparam logic [15:0] WAIT_MAX = 16'h88B8;
  localparam logic [16:0] WIN_MIN  = 17'h00004;
  localparam logic [16:0] WIN_MAX  = 17'h11170;
  // ==========================================
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] IX_CTRL   = 6'h00;
  localparam logic [5:0] IX_STAT   = 6'h01;
  localparam logic [5:0] IX_STEP   = 6'h02;
  localparam logic [5:0] IX_SEL    = 6'h03;
  localparam logic [5:0] IX_LOSS   = 6'h10;
  localparam logic [5:0] IX_PHASE  = 6'h18;
  localparam logic [5:0] IX_PLL    = 6'h20;
  localparam logic [5:0] IX_OUT    = 6'h30;
  localparam logic [1:0] PW_CFG    = 2'h0;
  localparam logic [1:0] PW_WAIT   = 2'h1;
  localparam logic [1:0] PW_WIN    = 2'h2;
  localparam logic [1:0] PW_SIZE   = 2'h3;
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_FBK0  = 1;
  localparam int CTRL_FBK1  = 2;
  localparam logic [31:0] PRIO_RST = 32'h0000_4688;
  // ==========================================
  // carriers
  typedef enum logic [0:0] {ST_TRACK = 1'b0, ST_HOLD = 1'b1} sel_state_t;
  typedef struct packed {logic feedback; logic [1:0] pll;} out_src_t;
  typedef struct packed {
    logic [13:0] rsvd; logic pinStep; logic speedUp; logic revertive; logic [14:0] prio;
  } pll_cfg_t;
  typedef struct packed {logic [10:0] rsvd; logic [4:0] thresh; logic [15:0] period;} loss_cfg_t;
  typedef struct packed {logic rsvd; logic [14:0] limit; logic [15:0] code;} phase_cfg_t;
  typedef struct packed {
    logic rsvd; out_src_t src; logic [11:0] limit; logic [15:0] code;
  } out_cfg_t;
endpackage

// ==== dv/ref_switch_sva.sv ====
// bus, switching and output-routing checks on the control block's ports
`timescale 1ns/100ps
module ref_switch_sva #(
  parameter int MS_CYCLES = 50000
) (
  input logic                                                   clock,
  input logic                                                   rstn,
  input logic [7:0]                                             avs_address,
  input logic                                                   avs_read,
  input logic                                                   avs_write,
  input logic [31:0]                                            avs_writedata,
  input logic [3:0]                                             avs_byteenable,
  input logic [31:0]                                            avs_readdata,
  input logic                                                   avs_waitrequest,
  input logic [ref_switch_pkg::NUM_PLL-1:0][2:0]                pllSelInput,
  input logic [ref_switch_pkg::NUM_PLL-1:0]                     pllSwitch,
  input ref_switch_pkg::out_src_t [ref_switch_pkg::NUM_OUT-1:0] outSource,
  input logic                                                   gpioFreed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================
  // control word shadow
  logic wrCtrl;
  logic feedbackMode_r;
  logic latchSeen_r;
  assign wrCtrl = avs_write & ~avs_waitrequest & (avs_address[7:2] == 6'h00) & avs_byteenable[0];
  always_ff @(posedge clock) begin
    if (!rstn) begin
      feedbackMode_r <= 1'h0;
      latchSeen_r    <= 1'h0;
    end else if (wrCtrl) begin
      feedbackMode_r <= avs_writedata[1];
      latchSeen_r    <= latchSeen_r | avs_writedata[0];
    end
  end
  // ==========================================
  // properties
  AST_ANSWER_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  AST_ANSWER_ONCE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[7:4] == 4'hF |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STEP_READS_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h02 |-> avs_readdata == 32'h0)
    else $error("step trigger register read not zero");
  AST_SWITCH_FLAG: assert property ($changed(pllSelInput[0]) |-> pllSwitch[0])
    else $error("input changed without realign pulse");
  AST_SEL_IN_RANGE: assert property (pllSelInput[0] <= 3'h4 && pllSelInput[3] <= 3'h4)
    else $error("selected input outside the input set");
  AST_FIRST_OUT_FEEDBACK: assert property (feedbackMode_r && $past(feedbackMode_r) |-> outSource[0].feedback && !outSource[0].pll[1])
    else $error("first output not feedback of first pair");
  AST_LATCH_OFF: assert property (!latchSeen_r |-> !gpioFreed)
    else $error("pins freed while latching never enabled");
endmodule // ref_switch_sva

bind ref_switch_holdover_ctrl ref_switch_sva #(.MS_CYCLES(MS_CYCLES)) chk (
  .clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pllSelInput(pllSelInput),
  .pllSwitch(pllSwitch), .outSource(outSource), .gpioFreed(gpioFreed)
);

// ==== dv/ref_clk_model.sv ====
// reference clock sources: one square wave per input, parked low when stopped
`timescale 1ns/100ps
module ref_clk_model #(
  parameter int HALF = 5
) (
  input  logic       clock,
  input  logic [4:0] run,
  output logic [4:0] refClk
);
  int   cnt = 0;
  logic phase = 1'h0;
  always @(posedge clock) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) phase <= ~phase;
  end
  assign refClk = run & {5{phase}};
endmodule // ref_clk_model

// ==== dv/tb_top.sv ====
// self-checking bench for the reference switch and holdover block
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [4:0] refRun = 5'h1F, refClkIn;
  logic chipResetNPin = 1'h1, stepIncPin = 1'h0, stepDecPin = 1'h0, gpioFreed;
  logic [3:0] gpioIn = 4'h0, pllLocked = 4'h0, pllHoldover, pllFastLock, gpioLatched;
  logic [3:0][31:0] pllFreqWord = {4{32'h1000_0000}}, pllFreqCtl;
  logic [3:0][2:0] pllSelInput;
  logic [3:0][15:0] pllPhaseOffset;
  logic [11:0][15:0] outDelayCode;
  ref_switch_pkg::out_src_t [11:0] outSource;
  int n_fail = 0, cmp_count = 0;
  always #10 clock = ~clock;
  ref_clk_model src (.clock(clock), .run(refRun), .refClk(refClkIn));
  ref_switch_holdover_ctrl #(.MS_CYCLES(20)) dut (.clock(clock), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .refClkIn(refClkIn), .chipResetNPin(chipResetNPin),
    .gpioIn(gpioIn), .stepIncPin(stepIncPin), .stepDecPin(stepDecPin),
    .pllFreqWord(pllFreqWord), .pllFreqLocked(pllLocked), .pllPhaseLocked(pllLocked),
    .pllFreqCtl(pllFreqCtl), .pllHoldover(pllHoldover), .pllSelInput(pllSelInput),
    .pllSwitch(), .pllPhaseOffset(pllPhaseOffset), .pllFastLock(pllFastLock),
    .outDelayCode(outDelayCode), .outSource(outSource), .gpioLatched(gpioLatched),
    .gpioFreed(gpioFreed));
  // ==========================================
  // helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clock);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    bus(0, 8'h80, 32'h0); chk("priority reset", 32'h0000_4688, rd);
    bus(0, 8'h00, 32'h0); chk("control reset", 32'h0, rd);
    bus(0, 8'hFC, 32'h0); chk("unmapped read", 32'h0, rd);
  endtask
  task automatic t_switch();
    for (int i = 0; i < 5; i++) bus(1, 8'h40 + 8'(4 * i), {11'h0, (i == 4) ? 5'h10 : 5'h02, 16'h0010});
    refRun <= 5'h1E;
    for (int i = 0; i < 300 && pllSelInput[0] !== 3'h1; i++) @(posedge clock);
    chk("switch to next", 32'h1, pllSelInput[0]);
    bus(0, 8'h04, 32'h0); chk("lost flags", 32'h01, rd[4:0]);
    refRun <= 5'h1F;
    repeat (100) @(posedge clock);
    chk("non-revertive stays", 32'h1, pllSelInput[0]);
    bus(1, 8'h80, 32'h0000_C688);
    for (int i = 0; i < 100 && pllSelInput[0] !== 3'h0; i++) @(posedge clock);
    chk("revertive returns", 32'h0, pllSelInput[0]);
  endtask
  task automatic t_hold();
    bus(1, 8'h84, 32'h2);
    bus(1, 8'h88, 32'h4);
    repeat (200) @(posedge clock);
    refRun <= 5'h00;
    for (int i = 0; i < 300 && pllHoldover[0] !== 1'h1; i++) @(posedge clock);
    chk("enter holdover", 32'h1, pllHoldover[0]);
    pllFreqWord <= {4{32'h2000_0000}};
    repeat (5) @(posedge clock);
    chk("frozen frequency", 32'h1000_0000, pllFreqCtl[0]);
    refRun <= 5'h1F;
    for (int i = 0; i < 300 && pllHoldover[0] !== 1'h0; i++) @(posedge clock);
    chk("leave holdover", 32'h0, pllHoldover[0]);
    pllFreqWord <= {4{32'h1000_0000}};
    repeat (5) @(posedge clock);
  endtask
  task automatic t_step();
    bus(1, 8'h8C, 32'h5);
    bus(1, 8'h08, 32'h1);
    repeat (3) @(posedge clock);
    chk("register step up", 32'h1000_0005, pllFreqCtl[0]);
    bus(1, 8'h8C, 32'hFFFF_FFFD);
    repeat (3) @(posedge clock);
    chk("size write alone", 32'h1000_0005, pllFreqCtl[0]);
    bus(1, 8'h80, 32'h0002_C688);
    stepDecPin <= 1'h1;
    repeat (3) @(posedge clock);
    stepDecPin <= 1'h0;
    repeat (8) @(posedge clock);
    chk("pin step down", 32'h1000_0008, pllFreqCtl[0]);
  endtask
  task automatic t_phase();
    bus(1, 8'h60, 32'h0100_0010);
    bus(1, 8'hC4, 32'h0100_0007);
    bus(1, 8'hCC, 32'h0005_0009);
    repeat (3) @(posedge clock);
    chk("input phase", 32'h0010, pllPhaseOffset[0]);
    chk("output delay", 32'h0007, outDelayCode[1]);
    chk("aligned output", 32'h0000, outDelayCode[2]);
    chk("delay clamp", 32'h0005, outDelayCode[3]);
  endtask
  task automatic t_misc();
    bus(1, 8'h00, 32'h2);
    repeat (3) @(posedge clock);
    chk("first output feedback", 32'h1, outSource[0].feedback);
    bus(1, 8'h80, 32'h0001_C688);
    repeat (3) @(posedge clock);
    chk("fast lock on", 32'h1, pllFastLock[0]);
    pllLocked <= 4'hF;
    repeat (5) @(posedge clock);
    chk("fast lock off", 32'h0, pllFastLock[0]);
    bus(1, 8'h00, 32'h7);
    gpioIn <= 4'hA;
    chipResetNPin <= 1'h0;
    repeat (4) @(posedge clock);
    chipResetNPin <= 1'h1;
    repeat (30) @(posedge clock);
    gpioIn <= 4'h5;
    chk("latched pins", 32'hA, gpioLatched);
    chk("pins freed", 32'h1, gpioFreed);
    chk("last output feedback", 32'h3, {outSource[11].feedback, outSource[11].pll[1]});
    bus(0, 8'h04, 32'h0); chk("latched status", 32'hA, rd[19:16]);
    chk("freed status", 32'h1, rd[12]);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    repeat (200) @(posedge clock);
    t_regs();
    t_switch();
    t_hold();
    t_step();
    t_phase();
    t_misc();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report();
  end
endmodule // tb_top
